// File: src/psm_controller.sv
`timescale 1ns/100ps
`default_nettype none
module psm_controller
   import psm_pkg::*;
(
   input  wire logic               clk,
   input  wire logic               resetn,
   psm_if.ctl                      bus,
   input  wire logic               reqValid,
   input  wire logic               reqWrite,
   input  wire psm_pkg::psm_addr_t reqAddr,
   input  wire psm_pkg::psm_data_t reqData,
   output logic                    ready,
   output logic                    rdValid,
   output psm_pkg::psm_data_t      rdData
);
   import psm_pkg::*;

   typedef enum logic [1:0] {
      CTL_PRE,
      CTL_RESET,
      CTL_WAIT,
      CTL_RUN
   } psm_ctl_phase_t;

   typedef struct packed {
      psm_ctl_phase_t   phase;
      logic [CNT_W-1:0] count;
      logic             initN;
      logic             readN;
      logic             writeN;
      psm_addr_t        addr;
      logic [1:0]       wrPipe;
      psm_data_t        wrHold0;
      psm_data_t        wrHold1;
      psm_data_t        wrData;
      logic [2:0]       rdPipe;
      logic             ready;
      logic             rdValid;
      psm_data_t        rdData;
   } psm_ctl_state_t;

   psm_ctl_state_t st;
   psm_ctl_state_t next_st;

   always_comb begin
      next_st         = st;
      next_st.readN   = 1'b1;
      next_st.writeN  = 1'b1;
      next_st.rdValid = 1'b0;
      next_st.count   = st.count + 1'b1;
      case (st.phase)
         CTL_PRE: begin
            if (st.count == CNT_W'(PRE_RESET_CYCLES - 1)) begin
               next_st.phase = CTL_RESET;
               next_st.initN = 1'b0;
            end
         end
         CTL_RESET: begin
            if (st.count == CNT_W'(PRE_RESET_CYCLES + RESET_CYCLES - 1)) begin
               next_st.phase = CTL_WAIT;
               next_st.initN = 1'b1;
            end
         end
         CTL_WAIT: begin
            if (st.count == CNT_W'(POWERUP_CYCLES - 1)) begin
               next_st.phase = CTL_RUN;
               next_st.ready = 1'b1;
            end
         end
         CTL_RUN: begin
            next_st.count = st.count;
            if (reqValid) begin
               // One strobe only per edge, never both.
               next_st.readN  = reqWrite;
               next_st.writeN = !reqWrite;
               next_st.addr   = reqAddr;
            end
         end
         default: next_st.phase = CTL_PRE;
      endcase
      // Write data leaves two edges after the command was driven.
      next_st.wrPipe  = {st.wrPipe[0], st.phase == CTL_RUN && reqValid && reqWrite};
      next_st.wrHold0 = reqData;
      next_st.wrHold1 = st.wrHold0;
      // Driving the word one edge earlier would let a following write
      // overwrite it before the memory samples it.
      if (st.wrPipe[1]) begin
         next_st.wrData = st.wrHold1;
      end
      // Memory answers on the second edge after our drive edge; we capture it on the third.
      next_st.rdPipe = {st.rdPipe[1:0], st.phase == CTL_RUN && reqValid && !reqWrite};
      if (st.rdPipe[2]) begin
         next_st.rdValid = 1'b1;
         next_st.rdData  = bus.rdData;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         st        <= '0;
         st.phase  <= CTL_PRE;
         st.initN  <= 1'b1;
         st.readN  <= 1'b1;
         st.writeN <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   assign bus.initN  = st.initN;
   assign bus.readN  = st.readN;
   assign bus.writeN = st.writeN;
   assign bus.addr   = st.addr;
   assign bus.wrData = st.wrData;
   assign ready      = st.ready;
   assign rdValid    = st.rdValid;
   assign rdData     = st.rdData;
endmodule
`default_nettype wire

// File: src/psm_pkg.sv
package psm_pkg;

   // ------------------------------------------------------------
   // Geometry
   // ------------------------------------------------------------
   localparam int ADDR_W     = 15;
   localparam int DATA_W     = 32;
   localparam int WORDS      = 32768;

   // ------------------------------------------------------------
   // Initialization timing, in clock cycles
   // ------------------------------------------------------------
   localparam int CLK_MHZ          = 10;
   localparam int PRE_RESET_CYCLES = 2;
   localparam int RESET_CYCLES     = 10;
   localparam int POWERUP_CYCLES   = 128;
   localparam int CNT_W            = 8;

   typedef logic [ADDR_W-1:0] psm_addr_t;
   typedef logic [DATA_W-1:0] psm_data_t;

   typedef enum logic [1:0] {
      PSM_NOP,
      PSM_READ,
      PSM_WRITE,
      PSM_ILLEGAL
   } psm_op_t;

   function automatic psm_op_t psm_decode(input logic readN, input logic writeN);
      psm_op_t op;
      op = PSM_NOP;
      case ({readN, writeN})
         2'b01:   op = PSM_READ;
         2'b10:   op = PSM_WRITE;
         2'b00:   op = PSM_ILLEGAL;
         default: op = PSM_NOP;
      endcase
      return op;
   endfunction

endpackage

// File: src/psm_if.sv
`timescale 1ns/100ps
`default_nettype none
interface psm_if;
   import psm_pkg::*;
   logic      initN;
   psm_addr_t addr;
   logic      readN;
   logic      writeN;
   psm_data_t wrData;
   psm_data_t rdData;

   modport mem (
      input  initN,
      input  addr,
      input  readN,
      input  writeN,
      input  wrData,
      output rdData
   );

   modport ctl (
      output initN,
      output addr,
      output readN,
      output writeN,
      output wrData,
      input  rdData
   );
endinterface
`default_nettype wire

// File: src/psm_memory.sv
// Operation
// - Capture address and strobes each rising edge.
// - Read data driven one cycle after next.
// - Write data taken two cycles after command.
// - Array is 32768 words by 32 bits.
// - Synchronous init reset, array kept intact.
// - Clock runs two cycles before init reset.
// - Init reset held low ten clock periods.
// - Wait 128 cycles before first access.
`timescale 1ns/100ps
`default_nettype none
module psm_memory
   import psm_pkg::*;
(
   input  wire logic clk,
   input  wire logic resetn,
   psm_if.mem        bus
);
   import psm_pkg::*;

   // ------------------------------------------------------------
   // Pipeline state
   // ------------------------------------------------------------
   typedef struct packed {
      logic      cmdRead;
      logic      cmdWrite;
      psm_addr_t cmdAddr;
      logic      dataWrite;
      psm_addr_t dataAddr;
      psm_data_t rdData;
   } psm_mem_state_t;

   psm_mem_state_t st;
   psm_mem_state_t next_st;
   psm_data_t      mem [WORDS];
   psm_op_t        op;

   // The array sits outside the state struct: it has no reset, so the
   // initialization reset cannot disturb stored words.
   always_comb begin
      op      = psm_decode(bus.readN, bus.writeN);
      next_st = st;
      // Stage 1: command edge captures address and strobes.
      next_st.cmdRead  = (op == PSM_READ);
      next_st.cmdWrite = (op == PSM_WRITE);
      next_st.cmdAddr  = bus.addr;
      // Stage 2: next edge opens the data cycle.
      next_st.dataWrite = st.cmdWrite;
      next_st.dataAddr  = st.cmdAddr;
      if (st.cmdRead) begin
         next_st.rdData = mem[st.cmdAddr];
      end
      if (!bus.initN) begin
         next_st.cmdRead   = 1'b0;
         next_st.cmdWrite  = 1'b0;
         next_st.dataWrite = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // Late write: data arrives in the cycle after the second edge and is
   // sampled at the third edge.
   always_ff @(posedge clk) begin
      if (st.dataWrite) begin
         mem[st.dataAddr] <= bus.wrData;
      end
   end

   assign bus.rdData = st.rdData;
endmodule
`default_nettype wire

// File: bench/psm_sva.sv
`timescale 1ns/100ps
`default_nettype none
module psm_sva
   import psm_pkg::*;
(
   input wire logic               clk,
   input wire logic               resetn,
   input wire logic               initN,
   input wire psm_pkg::psm_addr_t addr,
   input wire logic               readN,
   input wire logic               writeN,
   input wire psm_pkg::psm_data_t wrData,
   input wire psm_pkg::psm_data_t rdData
);
   import psm_pkg::*;
   // ---
   // Checks
   // ---
   logic [7:0] up;
   logic [4:0] low;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         up  <= 8'h00;
         low <= 5'h00;
      end else begin
         up  <= (up == 8'hff) ? up : up + 8'h01;
         low <= initN ? 5'h00 : low + 5'h01;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   // A write at edge E-5 stores the word seen at E-3; a read of the same
   // address at E-2 shows it at E, unless a write at E-4 landed in between.
   property p_wr_rd;
      !$past(writeN, 5) && !$past(readN, 2) && $past(addr, 5) == $past(addr, 2)
         && !(!$past(writeN, 4) && $past(addr, 4) == $past(addr, 2))
         |-> rdData == $past(wrData, 3);
   endproperty
   a_one_strobe: assert property (readN || writeN)
      else $error("both strobes low");
   a_pre_init: assert property (up < 8'h02 |-> initN)
      else $error("init low too soon");
   a_init_len: assert property ($rose(initN) |-> low >= 5'h0a)
      else $error("init pulse short");
   a_init_once: assert property ($rose(initN) |=> initN [*8])
      else $error("init pulse repeated");
   a_no_early: assert property (up < 8'h80 |-> readN && writeN)
      else $error("access before wait");
   a_init_quiet: assert property (!initN |-> readN && writeN)
      else $error("access during init");
   a_rd_hold: assert property ($past(readN, 2) |-> $stable(rdData))
      else $error("read data moved");
   a_wr_rd_data: assert property (p_wr_rd)
      else $error("read data wrong");
   c_rd_rd: cover property (!readN ##1 !readN);
   c_wr_wr: cover property (!writeN ##1 !writeN);
   c_wr_rd: cover property (!writeN ##1 !readN);
endmodule
`default_nettype wire

// File: bench/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top import psm_pkg::*;;
   // ---
   // Bench
   // ---
   logic        clk, resetn, reqValid, reqWrite, ready, rdValid;
   psm_addr_t   reqAddr;
   psm_data_t   reqData, rdData, mem [psm_addr_t], expQ [$];
   logic [31:0] seed = 32'ha70d_f399;
   int          n_errors, tests_run;
   psm_if bus ();
   psm_memory i_psm_memory (.clk(clk), .resetn(resetn), .bus(bus));
   psm_controller i_psm_controller (.clk(clk), .resetn(resetn), .bus(bus),
      .reqValid(reqValid), .reqWrite(reqWrite), .reqAddr(reqAddr), .reqData(reqData),
      .ready(ready), .rdValid(rdValid), .rdData(rdData));
   psm_sva i_psm_sva (.clk(clk), .resetn(resetn), .initN(bus.initN), .addr(bus.addr),
      .readN(bus.readN), .writeN(bus.writeN), .wrData(bus.wrData), .rdData(bus.rdData));
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic check(input psm_data_t seen, input psm_data_t want);
      tests_run++;
      if (seen !== want) begin
         n_errors++;
         $display("wrong value at %0t: %h expected %h", $time, seen, want);
      end
   endtask
   task automatic stop_test();
      if (expQ.size() != 0) n_errors++;
      $display("comparisons %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic req(input logic w, input psm_addr_t a, input psm_data_t d);
      @(posedge clk);
      #1;
      {reqValid, reqWrite, reqAddr, reqData} = {1'b1, w, a, d};
      if (w) mem[a] = d;
      else expQ.push_back(mem[a]);
   endtask
   task automatic idle(input int n);
      repeat (n) begin
         @(posedge clk);
         #1;
         reqValid = 1'b0;
      end
   endtask
   task automatic start();
      resetn = 1'b0;
      repeat (10) @(posedge clk);
      #1;
      resetn = 1'b1;
      for (int i = 0; i < 300 && ready !== 1'b1; i++) @(posedge clk);
      check(psm_data_t'(ready), 32'h0000_0001);
   endtask
   always @(posedge clk) begin
      if (rdValid === 1'b1) check(rdData, expQ.pop_front());
   end
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   initial begin
      #3_000_000;
      n_errors++;
      stop_test();
   end
   initial begin
      {resetn, reqValid, reqWrite, reqAddr, reqData} = '0;
      start();
      req(1'b1, 15'h7fff, 32'hffff_ffff);
      idle(2);
      req(1'b0, 15'h7fff, 32'h0000_0000);
      for (int i = 0; i < 128; i++) req(1'b1, psm_addr_t'(i), xs());
      // Reads and writes use disjoint halves so no read races a late write.
      for (int i = 0; i < 300; i++) begin
         seed = xs();
         req(seed[0], psm_addr_t'({seed[0], seed[8:3]}), xs());
      end
      idle(6);
      $display("test traffic done");
      start();
      for (int i = 0; i < 128; i++) req(1'b0, psm_addr_t'(i), 32'h0000_0000);
      idle(6);
      $display("test reset keeps array done");
      stop_test();
   end
endmodule
`default_nettype wire
